// *** include/tpas_pkg.sv ***
// ------------------------------------------------------------------------
// Types shared by the sequencer and its output buffer
// ------------------------------------------------------------------------
package tpas_pkg;

  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_TWO,
    MODE_FOUR
  } tpas_mode_e;

  typedef enum logic [1:0] {
    SEL_FIRST,
    SEL_SECOND,
    SEL_CLEAR
  } tpas_adcsel_e;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_HOLD,
    ST_P1_GO,
    ST_P1_WAIT,
    ST_DAC_SET,
    ST_P2_GO,
    ST_P2_WAIT,
    ST_CLR_GO,
    ST_CLR_WAIT,
    ST_STORE,
    ST_CHAN_SET
  } tpas_state_e;

  typedef struct packed {
    logic [15:0] sample;
    logic        overHigh;
    logic        overLow;
    logic [1:0]  chan;
  } tpas_result_s;

endpackage

// *** include/tpas_regs.svh ***
`ifndef TPAS_REGS_SVH
`define TPAS_REGS_SVH

// ------------------------------------------------------------------------
// Timing figures and codes
// ------------------------------------------------------------------------
`define TPAS_CLK_PERIOD_NS   100
`define TPAS_HOLD_SETTLE_NS  1000
`define TPAS_CHAN_SETTLE_NS  500
`define TPAS_DAC_SETTLE_NS   2000
`define TPAS_PASS_BITS       8
`define TPAS_WORD_BITS       16
`define TPAS_OVER_HIGH_CODE  8'hff
`define TPAS_OVER_LOW_CODE   8'h00
`define TPAS_DITHER_SEED     16'hace1
`define TPAS_DITHER_TAPS     16'hb400
`define TPAS_SAMPLE_MAX      16'hffff

`endif

// *** verif/tpas_dsp_model.sv ***
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Downstream processor taking serial samples
// ----------------------------------------------------------------------
module tpas_dsp_model (
  input wire logic              core_clk,
  input wire logic              srst,
  input wire logic              stall,
  input wire logic              conversion_result_stream,
  input wire logic              streamFrame,
  input wire logic [1:0]        streamChan,
  input wire logic              overHigh,
  input wire logic              overLow,
  output logic                  streamReady,
  output tpas_pkg::tpas_result_s gotWord,
  output logic                  gotStrobe
);
  logic [15:0] shift_reg;
  logic        frame_reg;

  // Ready is a registered level, dropped while the bench asks for a stall.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      streamReady <= 1'b0;
    end else begin
      streamReady <= !stall;
    end
  end

  // Shifts bits in MSB first and hands the word over as the frame ends.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      shift_reg <= 16'h0000;
      frame_reg <= 1'b0;
      gotStrobe <= 1'b0;
      gotWord   <= '0;
    end else begin
      frame_reg <= streamFrame;
      gotStrobe <= frame_reg && !streamFrame;
      if (streamFrame) begin
        shift_reg <= {shift_reg[14:0], conversion_result_stream};
      end
      if (frame_reg && !streamFrame) begin
        gotWord <= {shift_reg, overHigh, overLow, streamChan};
      end
    end
  end
endmodule

// *** verif/tpas_sequencer_properties.sv ***
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Port-level properties of the sequencer
// ----------------------------------------------------------------------
module tpas_sequencer_properties #(
  parameter bit FOUR_CHAN_BUILD = 1'b1
) (
  input wire logic                   core_clk,
  input wire logic                   srst,
  input wire logic                   sampleStart,
  input wire tpas_pkg::tpas_mode_e   measMode,
  input wire logic                   adcDonePin,
  input wire logic [7:0]             adcDataPin,
  input wire logic                   streamReady,
  input wire logic                   holdAll,
  input wire logic [1:0]             chanSel,
  input wire tpas_pkg::tpas_adcsel_e adcInSel,
  input wire logic                   adcStart,
  input wire logic [15:0]            dacWord,
  input wire logic                   seqBusy,
  input wire logic                   conversion_result_stream,
  input wire logic                   streamFrame,
  input wire logic [1:0]             streamChan,
  input wire logic                   converter_overload_high_flag,
  input wire logic                   converter_overload_low_flag
);
  tpas_pkg::tpas_adcsel_e lastSel_reg;
  tpas_pkg::tpas_mode_e   mode_reg;
  logic [4:0]             frameLen_reg;

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);

  // Keeps the selector of the latest conversion start.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lastSel_reg <= tpas_pkg::SEL_CLEAR;
    end else if (adcStart) begin
      lastSel_reg <= adcInSel;
    end
  end

  // Counts the cycles of the running frame, so its length needs no long repetition.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      frameLen_reg <= 5'h00;
    end else if (streamFrame) begin
      frameLen_reg <= frameLen_reg + 5'h01;
    end else begin
      frameLen_reg <= 5'h00;
    end
  end

  // Keeps the mode taken with the latest accepted start.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_reg <= tpas_pkg::MODE_SINGLE;
    end else if (sampleStart && !holdAll) begin
      mode_reg <= measMode;
    end
  end

  a_start_takes_hold: assert property (sampleStart && !holdAll |=> holdAll)
    else $error("hold not raised after an accepted start");
  a_hold_covers_conv: assert property (adcStart |-> holdAll)
    else $error("conversion started without hold");
  a_clear_then_first: assert property (adcStart && lastSel_reg == tpas_pkg::SEL_CLEAR
    |-> adcInSel == tpas_pkg::SEL_FIRST)
    else $error("first pass not after clearing pass");
  a_first_then_second: assert property (adcStart && lastSel_reg == tpas_pkg::SEL_FIRST
    |-> adcInSel == tpas_pkg::SEL_SECOND)
    else $error("second pass not after first pass");
  a_second_then_clear: assert property (adcStart && lastSel_reg == tpas_pkg::SEL_SECOND
    |-> adcInSel == tpas_pkg::SEL_CLEAR)
    else $error("clearing pass not after second pass");
  a_dac_holds_residue: assert property (adcStart && adcInSel == tpas_pkg::SEL_SECOND
    |=> $stable(dacWord) [*8])
    else $error("correction word moved during second pass");
  a_single_fixed: assert property (adcStart && mode_reg == tpas_pkg::MODE_SINGLE
    |-> chanSel == 2'h0)
    else $error("single mode left channel one");
  a_two_alternates: assert property (adcStart && mode_reg == tpas_pkg::MODE_TWO
    |-> !chanSel[1])
    else $error("two-channel mode used channel three or four");
  a_frame_sixteen: assert property ($fell(streamFrame) |-> frameLen_reg == 5'h10)
    else $error("frame not sixteen cycles long");
  a_frame_not_long: assert property (streamFrame |-> frameLen_reg < 5'h10)
    else $error("frame longer than sixteen cycles");
  a_busy_is_hold: assert property (seqBusy == holdAll)
    else $error("busy differs from hold");
  a_frame_waits_ready: assert property (!streamReady && !streamFrame |=> !streamFrame)
    else $error("frame started while receiver not ready");
  a_flags_steady: assert property (streamFrame && $past(streamFrame) |-> $stable(
    {converter_overload_high_flag, converter_overload_low_flag, streamChan}))
    else $error("flags or channel moved inside a frame");
  a_flags_exclusive: assert property (!(converter_overload_high_flag
    && converter_overload_low_flag))
    else $error("both overload flags set");

  c_high_frame: cover property ($rose(streamFrame) ##1 converter_overload_high_flag);
  c_low_frame: cover property ($rose(streamFrame) ##1 converter_overload_low_flag);
  c_four_start: cover property (adcStart && mode_reg == tpas_pkg::MODE_FOUR && chanSel == 2'h3);
endmodule

bind tpas_sequencer tpas_sequencer_properties #(.FOUR_CHAN_BUILD(FOUR_CHAN_BUILD))
  tpas_sequencer_properties_inst (.core_clk(core_clk), .srst(srst),
  .sampleStart(sampleStart), .measMode(measMode), .adcDonePin(adcDonePin),
  .adcDataPin(adcDataPin), .streamReady(streamReady), .holdAll(holdAll),
  .chanSel(chanSel), .adcInSel(adcInSel), .adcStart(adcStart), .dacWord(dacWord),
  .seqBusy(seqBusy), .conversion_result_stream(conversion_result_stream),
  .streamFrame(streamFrame), .streamChan(streamChan),
  .converter_overload_high_flag(converter_overload_high_flag),
  .converter_overload_low_flag(converter_overload_low_flag));

// *** verif/tpas_sequencer_tb.sv ***
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Self-checking bench with a converter model and a serial receiver
// ----------------------------------------------------------------------
module tpas_sequencer_tb;
  logic                   core_clk, srst, sampleStart, adcDonePin, stall;
  logic                   streamReady, holdAll, adcStart, seqBusy, gotStrobe;
  logic                   conversion_result_stream, streamFrame;
  logic                   converter_overload_high_flag, converter_overload_low_flag;
  logic [7:0]             adcDataPin, conv;
  logic [1:0]             chanSel, streamChan;
  logic [15:0]            dacWord;
  tpas_pkg::tpas_mode_e   measMode;
  tpas_pkg::tpas_adcsel_e adcInSel;
  tpas_pkg::tpas_result_s gotWord;
  tpas_pkg::tpas_result_s gotQ[$];
  logic [15:0]            heldVal [4] = '{16'h12ff, 16'hffff, 16'h00ff, 16'h7aff};
  int                     n_errors, samples_checked, dly;

  tpas_sequencer tpas_sequencer_inst (.core_clk(core_clk), .srst(srst),
    .sampleStart(sampleStart), .measMode(measMode), .adcDonePin(adcDonePin),
    .adcDataPin(adcDataPin), .streamReady(streamReady), .holdAll(holdAll),
    .chanSel(chanSel), .adcInSel(adcInSel), .adcStart(adcStart), .dacWord(dacWord),
    .seqBusy(seqBusy), .conversion_result_stream(conversion_result_stream),
    .streamFrame(streamFrame), .streamChan(streamChan),
    .converter_overload_high_flag(converter_overload_high_flag),
    .converter_overload_low_flag(converter_overload_low_flag));

  tpas_dsp_model tpas_dsp_model_inst (.core_clk(core_clk), .srst(srst), .stall(stall),
    .conversion_result_stream(conversion_result_stream), .streamFrame(streamFrame),
    .streamChan(streamChan), .overHigh(converter_overload_high_flag),
    .overLow(converter_overload_low_flag), .streamReady(streamReady),
    .gotWord(gotWord), .gotStrobe(gotStrobe));

  // Clock of 100 ns period.
  always #50 core_clk = ~core_clk;

  // Residue seen by the second pass, limited to the converter range.
  function automatic logic [7:0] residue(input logic [15:0] v, input logic [15:0] d);
    logic [15:0] r;
    r = v - d;
    return (v < d) ? 8'h00 : ((r > 16'h00ff) ? 8'hff : r[7:0]);
  endfunction

  // Result that a held input should give on the stream.
  function automatic tpas_pkg::tpas_result_s expected(input int ch);
    expected.sample   = heldVal[ch];
    expected.overHigh = (heldVal[ch][15:8] == 8'hff);
    expected.overLow  = (heldVal[ch][15:8] == 8'h00);
    expected.chan     = ch[1:0];
  endfunction

  // Converter model: answers each start a few cycles later, then drops done.
  always @(posedge core_clk) begin
    if (srst) begin
      adcDonePin <= 1'b0;
      adcDataPin <= 8'h00;
      dly <= 0;
    end else if (adcStart) begin
      adcDonePin <= 1'b0;
      dly <= 1;
      case (adcInSel)
        tpas_pkg::SEL_FIRST:  conv <= heldVal[chanSel][15:8];
        tpas_pkg::SEL_SECOND: conv <= residue(heldVal[chanSel], dacWord);
        default:              conv <= 8'h5a;
      endcase
    end else if (dly != 0) begin
      dly <= (dly == 6) ? 0 : dly + 1;
      if (dly == 3) begin
        adcDonePin <= 1'b1;
        adcDataPin <= conv;
      end
      if (dly == 6) begin
        adcDonePin <= 1'b0;
        adcDataPin <= ~conv;
      end
    end
  end

  // Collects every word the receiver takes.
  always @(posedge core_clk) begin
    if (gotStrobe) begin
      gotQ.push_back(gotWord);
    end
  end

  task automatic check_result(input tpas_pkg::tpas_result_s got, input tpas_pkg::tpas_result_s exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected result at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_count(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected count at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Starts one sample period in the given mode.
  task automatic start_period(input tpas_pkg::tpas_mode_e m);
    @(posedge core_clk);
    sampleStart <= 1'b1;
    measMode <= m;
    @(posedge core_clk);
    sampleStart <= 1'b0;
  endtask

  // Waits for n words, compares them in ascending order, then checks none follow.
  task automatic expect_words(input int n);
    for (int k = 0; k < 3000 && gotQ.size() < n; k++) @(posedge core_clk);
    check_count(16'(gotQ.size()), 16'(n));
    for (int i = 0; i < n && gotQ.size() > 0; i++) check_result(gotQ.pop_front(), expected(i));
    repeat (300) @(posedge core_clk);
    check_count(16'(gotQ.size()), 16'h0000);
  endtask

  task automatic test_single();
    start_period(tpas_pkg::MODE_SINGLE);
    expect_words(1);
  endtask

  task automatic test_two();
    start_period(tpas_pkg::MODE_TWO);
    expect_words(2);
    start_period(tpas_pkg::tpas_mode_e'(2'h3));
    expect_words(2);
  endtask

  task automatic test_four();
    start_period(tpas_pkg::MODE_FOUR);
    expect_words(4);
  endtask

  // Receiver stalls through a whole period; no word may be lost or reordered.
  task automatic test_stall();
    stall <= 1'b1;
    start_period(tpas_pkg::MODE_FOUR);
    repeat (1500) @(posedge core_clk);
    check_count(16'(gotQ.size()), 16'h0000);
    stall <= 1'b0;
    expect_words(4);
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    core_clk = 1'b0;
    srst = 1'b1;
    sampleStart = 1'b0;
    measMode = tpas_pkg::MODE_SINGLE;
    stall = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    test_single();
    test_two();
    test_four();
    test_stall();
    tally_and_finish();
  end

  // Watchdog against a hang.
  initial begin
    repeat (30000) @(posedge core_clk);
    n_errors++;
    tally_and_finish();
  end
endmodule

// *** verilog/tpas_sequencer.sv ***
`timescale 1ns/10ps
`include "tpas_regs.svh"


module tpas_sequencer #(
  parameter bit FOUR_CHAN_BUILD = 1'b1
) (
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  input  wire logic                 sampleStart,
  input  wire tpas_pkg::tpas_mode_e measMode,
  input  wire logic                 adcDonePin,
  input  wire logic [7:0]           adcDataPin,
  input  wire logic                 streamReady,
  output logic                      holdAll,
  output logic [1:0]                chanSel,
  output tpas_pkg::tpas_adcsel_e    adcInSel,
  output logic                      adcStart,
  output logic [15:0]               dacWord,
  output logic                      seqBusy,
  output logic                      conversion_result_stream,
  output logic                      streamFrame,
  output logic [1:0]                streamChan,
  output logic                      converter_overload_high_flag,
  output logic                      converter_overload_low_flag
);

  // ----------------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------------
  localparam int HOLD_CYC = (`TPAS_HOLD_SETTLE_NS + `TPAS_CLK_PERIOD_NS - 1)
                            / `TPAS_CLK_PERIOD_NS;
  localparam int CHAN_CYC = (`TPAS_CHAN_SETTLE_NS + `TPAS_CLK_PERIOD_NS - 1)
                            / `TPAS_CLK_PERIOD_NS;
  localparam int DAC_CYC  = (`TPAS_DAC_SETTLE_NS + `TPAS_CLK_PERIOD_NS - 1)
                            / `TPAS_CLK_PERIOD_NS;
  localparam int PB       = `TPAS_PASS_BITS;
  localparam int WB       = `TPAS_WORD_BITS;

  tpas_pkg::tpas_state_e  state_reg;
  tpas_pkg::tpas_adcsel_e adcInSel_reg;
  tpas_pkg::tpas_result_s bufIn;
  tpas_pkg::tpas_result_s bufOut;
  logic [7:0]             waitCnt_reg;
  logic [1:0]             chanIdx_reg;
  logic [1:0]             lastChan_reg;
  logic                   holdAll_reg;
  logic                   adcStart_reg;
  logic [PB-1:0]          dataMeta_reg;
  logic [PB-1:0]          dataSync_reg;
  logic                   doneMeta_reg;
  logic                   doneSync_reg;
  logic                   donePrev_reg;
  logic                   doneRise;
  logic [PB-1:0]          firstWord_reg;
  logic [PB-1:0]          secondWord_reg;
  logic                   overHigh_reg;
  logic                   overLow_reg;
  logic [WB-1:0]          dither_reg;
  logic [WB-1:0]          dacWord_reg;
  logic [WB:0]            sum;
  logic [WB-1:0]          sample;
  logic                   bufInReady;
  logic                   bufOutValid;
  logic                   bufOutReady;
  logic [WB-1:0]          shift_reg;
  logic [4:0]             bitCnt_reg;
  logic                   frame_reg;
  logic                   serBit_reg;
  logic [1:0]             serChan_reg;
  logic                   flagHigh_reg;
  logic                   flagLow_reg;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------

  // Converter pins pass two flip-flops before any logic reads them.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      doneMeta_reg <= 1'b0;
      doneSync_reg <= 1'b0;
      donePrev_reg <= 1'b0;
      dataMeta_reg <= 8'h00;
      dataSync_reg <= 8'h00;
    end else begin
      doneMeta_reg <= adcDonePin;
      doneSync_reg <= doneMeta_reg;
      donePrev_reg <= doneSync_reg;
      dataMeta_reg <= adcDataPin;
      dataSync_reg <= dataMeta_reg;
    end
  end

  // A conversion is complete on the rising edge of the settled done level.
  assign doneRise = doneSync_reg && !donePrev_reg;

  // ----------------------------------------------------------------------
  // Conversion sequence
  // ----------------------------------------------------------------------

  // Main sequence: hold, three conversions per channel, then store.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg    <= tpas_pkg::ST_IDLE;
      waitCnt_reg  <= 8'h00;
      adcStart_reg <= 1'b0;
      adcInSel_reg <= tpas_pkg::SEL_CLEAR;
    end else begin
      adcStart_reg <= 1'b0;
      unique case (state_reg)
        tpas_pkg::ST_IDLE: begin
          if (sampleStart) begin
            state_reg   <= tpas_pkg::ST_HOLD;
            waitCnt_reg <= 8'(HOLD_CYC);
          end
        end
        tpas_pkg::ST_HOLD, tpas_pkg::ST_CHAN_SET: begin
          if (waitCnt_reg <= 8'h01) begin
            state_reg <= tpas_pkg::ST_P1_GO;
          end
          waitCnt_reg <= waitCnt_reg - 8'h01;
        end
        tpas_pkg::ST_P1_GO: begin
          adcInSel_reg <= tpas_pkg::SEL_FIRST;
          adcStart_reg <= 1'b1;
          state_reg    <= tpas_pkg::ST_P1_WAIT;
        end
        tpas_pkg::ST_P1_WAIT: begin
          if (doneRise) begin
            state_reg   <= tpas_pkg::ST_DAC_SET;
            waitCnt_reg <= 8'(DAC_CYC);
          end
        end
        tpas_pkg::ST_DAC_SET: begin
          if (waitCnt_reg <= 8'h01) begin
            state_reg <= tpas_pkg::ST_P2_GO;
          end
          waitCnt_reg <= waitCnt_reg - 8'h01;
        end
        tpas_pkg::ST_P2_GO: begin
          adcInSel_reg <= tpas_pkg::SEL_SECOND;
          adcStart_reg <= 1'b1;
          state_reg    <= tpas_pkg::ST_P2_WAIT;
        end
        tpas_pkg::ST_P2_WAIT: begin
          if (doneRise) begin
            state_reg <= tpas_pkg::ST_CLR_GO;
          end
        end
        tpas_pkg::ST_CLR_GO: begin
          adcInSel_reg <= tpas_pkg::SEL_CLEAR;
          adcStart_reg <= 1'b1;
          state_reg    <= tpas_pkg::ST_CLR_WAIT;
        end
        tpas_pkg::ST_CLR_WAIT: begin
          if (doneRise) begin
            state_reg <= tpas_pkg::ST_STORE;
          end
        end
        tpas_pkg::ST_STORE: begin
          if (bufInReady) begin
            if (chanIdx_reg == lastChan_reg) begin
              state_reg <= tpas_pkg::ST_IDLE;
            end else begin
              state_reg   <= tpas_pkg::ST_CHAN_SET;
              waitCnt_reg <= 8'(CHAN_CYC);
            end
          end
        end
        default: begin
          state_reg <= tpas_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Channel selection and hold
  // ----------------------------------------------------------------------

  // Mode sets the last channel; channels advance upward from channel 1.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      chanIdx_reg  <= 2'h0;
      lastChan_reg <= 2'h0;
    end else if (state_reg == tpas_pkg::ST_IDLE && sampleStart) begin
      chanIdx_reg <= 2'h0;
      if (measMode == tpas_pkg::MODE_FOUR && FOUR_CHAN_BUILD) begin
        lastChan_reg <= 2'h3;
      end else if (measMode == tpas_pkg::MODE_SINGLE) begin
        lastChan_reg <= 2'h0;
      end else begin
        lastChan_reg <= 2'h1;
      end
    end else if (state_reg == tpas_pkg::ST_STORE && bufInReady
                 && chanIdx_reg != lastChan_reg) begin
      chanIdx_reg <= chanIdx_reg + 2'h1;
    end
  end

  // All channels are held together until the last one is stored.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      holdAll_reg <= 1'b0;
    end else if (state_reg == tpas_pkg::ST_IDLE) begin
      holdAll_reg <= sampleStart;
    end else if (state_reg == tpas_pkg::ST_STORE && bufInReady
                 && chanIdx_reg == lastChan_reg) begin
      holdAll_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Pass words, dither and overload
  // ----------------------------------------------------------------------

  // Dither source, advanced once per channel conversion.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dither_reg <= `TPAS_DITHER_SEED;
    end else if (state_reg == tpas_pkg::ST_P1_GO) begin
      dither_reg <= {dither_reg[WB-2:0], ^(dither_reg & `TPAS_DITHER_TAPS)};
    end
  end

  // First word, overload flags and the dithered DAC word.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      firstWord_reg <= 8'h00;
      overHigh_reg  <= 1'b0;
      overLow_reg   <= 1'b0;
      dacWord_reg   <= 16'h0000;
    end else if (state_reg == tpas_pkg::ST_P1_WAIT && doneRise) begin
      firstWord_reg <= dataSync_reg;
      overHigh_reg  <= (dataSync_reg == `TPAS_OVER_HIGH_CODE);
      overLow_reg   <= (dataSync_reg == `TPAS_OVER_LOW_CODE);
    end else if (state_reg == tpas_pkg::ST_DAC_SET && waitCnt_reg == 8'(DAC_CYC)) begin
      dacWord_reg <= {firstWord_reg, dither_reg[PB-1:0]};
    end
  end

  // Second-pass word from the residue conversion.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      secondWord_reg <= 8'h00;
    end else if (state_reg == tpas_pkg::ST_P2_WAIT && doneRise) begin
      secondWord_reg <= dataSync_reg;
    end
  end

  // Second word added to the dithered first word, clamped at full scale.
  assign sum    = {1'b0, dacWord_reg} + {9'h000, secondWord_reg};
  assign sample = sum[WB] ? `TPAS_SAMPLE_MAX : sum[WB-1:0];

  assign bufIn.sample   = sample;
  assign bufIn.overHigh = overHigh_reg;
  assign bufIn.overLow  = overLow_reg;
  assign bufIn.chan     = chanIdx_reg;

  // ----------------------------------------------------------------------
  // Output buffer and serialiser
  // ----------------------------------------------------------------------

  tpas_skid_buffer u_buffer (
    .core_clk (core_clk),
    .srst     (srst),
    .inData   (bufIn),
    .inValid  (state_reg == tpas_pkg::ST_STORE),
    .inReady  (bufInReady),
    .outData  (bufOut),
    .outValid (bufOutValid),
    .outReady (bufOutReady)
  );

  // A new word is taken only when idle and the receiver is ready.
  assign bufOutReady = !frame_reg && streamReady;

  // Shift each result out MSB first, flags held for the whole frame.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      shift_reg    <= 16'h0000;
      bitCnt_reg   <= 5'h00;
      frame_reg    <= 1'b0;
      serBit_reg   <= 1'b0;
      serChan_reg  <= 2'h0;
      flagHigh_reg <= 1'b0;
      flagLow_reg  <= 1'b0;
    end else if (bufOutValid && bufOutReady) begin
      frame_reg    <= 1'b1;
      serBit_reg   <= bufOut.sample[WB-1];
      shift_reg    <= {bufOut.sample[WB-2:0], 1'b0};
      bitCnt_reg   <= 5'(WB - 1);
      serChan_reg  <= bufOut.chan;
      flagHigh_reg <= bufOut.overHigh;
      flagLow_reg  <= bufOut.overLow;
    end else if (frame_reg) begin
      if (bitCnt_reg == 5'h00) begin
        frame_reg  <= 1'b0;
        serBit_reg <= 1'b0;
      end else begin
        serBit_reg <= shift_reg[WB-1];
        shift_reg  <= {shift_reg[WB-2:0], 1'b0};
        bitCnt_reg <= bitCnt_reg - 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------

  // Busy mirrors the hold period so the next start is timed correctly.
  assign holdAll                      = holdAll_reg;
  assign chanSel                      = chanIdx_reg;
  assign adcInSel                     = adcInSel_reg;
  assign adcStart                     = adcStart_reg;
  assign dacWord                      = dacWord_reg;
  assign seqBusy                      = holdAll_reg;
  assign conversion_result_stream     = serBit_reg;
  assign streamFrame                  = frame_reg;
  assign streamChan                   = serChan_reg;
  assign converter_overload_high_flag = flagHigh_reg;
  assign converter_overload_low_flag  = flagLow_reg;

endmodule

// *** verilog/tpas_skid_buffer.sv ***
`timescale 1ns/10ps

// ------------------------------------------------------------------------
// Two-entry buffer with valid and ready on both sides
// ------------------------------------------------------------------------
module tpas_skid_buffer (
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  input  wire tpas_pkg::tpas_result_s inData,
  input  wire logic                 inValid,
  output logic                      inReady,
  output tpas_pkg::tpas_result_s    outData,
  output logic                      outValid,
  input  wire logic                 outReady
);

  tpas_pkg::tpas_result_s entry_reg [2];
  logic                   rdPtr_reg;
  logic                   wrPtr_reg;
  logic [1:0]             count_reg;
  logic                   push;
  logic                   pop;

  // Ready and valid are honest views of the fill level.
  assign inReady  = (count_reg != 2'h2);
  assign outValid = (count_reg != 2'h0);
  assign outData  = entry_reg[rdPtr_reg];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Storage is written only on an accepted word.
  always_ff @(posedge core_clk) begin
    if (push) begin
      entry_reg[wrPtr_reg] <= inData;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdPtr_reg <= 1'b0;
      wrPtr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        wrPtr_reg <= ~wrPtr_reg;
      end
      if (pop) begin
        rdPtr_reg <= ~rdPtr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end

endmodule
